// ### dv/iops_pin_model.sv
// board-side pin model: resolves every package pin from device, board drivers and pull-ups
`timescale 1ns/1ps
`default_nettype none

module iops_pin_model (
  input  wire logic                  i_ref_clk,
  input  wire iops_pkg::iops_ports_t i_pin_out,
  input  wire iops_pkg::iops_ports_t i_pin_oe,
  input  wire iops_pkg::iops_pull_t  i_pull_en,
  input  wire iops_pkg::iops_ports_t i_ext_val,
  input  wire iops_pkg::iops_ports_t i_ext_en,
  output iops_pkg::iops_ports_t      o_level
);
  import iops_pkg::*;

  logic float_q = 1'b0;

  // an undriven pin wanders every cycle so a stale value never passes for a read
  always_ff @(posedge i_ref_clk) float_q <= ~float_q;

  // device driver wins, then the board, then the pull-up, else the pin floats
  always_comb begin
    for (int p = 0; p < 13; p++) begin
      for (int b = 0; b < 8; b++) begin
        if (i_pin_oe[p][b]) o_level[p][b] = i_pin_out[p][b];
        else if (i_ext_en[p][b]) o_level[p][b] = i_ext_val[p][b]; // board drives a pin the device leaves undriven where its enable bit is set
        else if (p >= 6 && p <= 10 && i_pull_en[p-6][b]) o_level[p][b] = 1'b1;
        else o_level[p][b] = float_q ^ b[0];
      end
    end
  end
endmodule // iops_pin_model

`default_nettype wire

// ### dv/test_io_port_function_select.sv
// self-checking bench for the io port function select block
`timescale 1ns/1ps
`default_nettype none
`include "iops_consts.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end

module test_io_port_function_select;
  import iops_pkg::*;

  logic        i_ref_clk, i_arst_n, i_man_rst, i_hw_stby, i_wait_pin_enable, i_clk_phi, i_wr_en;
  logic        o_wait_req, o_ready;
  logic [2:0]  i_mode;
  logic [3:0]  i_wr_port, i_rd_port;
  logic [7:0]  i_wr_data, o_rd_data;
  logic [15:0] o_data_in;
  logic [7:4]  o_irq_req;
  iops_reg_e   i_wr_reg, i_rd_reg;
  iops_bus_s   i_bus;
  iops_ports_t i_pin, o_pin, o_pin_oe, ext_val, ext_en;
  iops_pull_t  o_pullup_en;
  int          n_errors = 0;
  int          n_tests = 0;
  int          cyc = 0;
  logic [31:0] seed = 32'h03fe;
  int          dir [13], lat [13], odc [13], pul [5];

  iops_top iops_top_inst (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_man_rst(i_man_rst),
    .i_hw_stby(i_hw_stby), .i_mode(i_mode), .i_wait_pin_enable(i_wait_pin_enable), .i_clk_phi(i_clk_phi),
    .i_bus(i_bus), .i_wr_en(i_wr_en), .i_wr_port(i_wr_port), .i_wr_reg(i_wr_reg), .i_wr_data(i_wr_data),
    .i_rd_port(i_rd_port), .i_rd_reg(i_rd_reg), .i_pin(i_pin),
    .o_pin(o_pin), .o_pin_oe(o_pin_oe), .o_pullup_en(o_pullup_en), .o_rd_data(o_rd_data),
    .o_data_in(o_data_in), .o_irq_req(o_irq_req), .o_wait_req(o_wait_req), .o_ready(o_ready));

  iops_pin_model iops_pin_model_inst (.i_ref_clk(i_ref_clk), .i_pin_out(o_pin), .i_pin_oe(o_pin_oe),
    .i_pull_en(o_pullup_en), .i_ext_val(ext_val), .i_ext_en(ext_en), .o_level(i_pin));

  // ****************************************
  // clock, timeout and verdict
  // ****************************************
  initial begin
    i_ref_clk = 1'b0;
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end

  // the whole run needs about 620 cycles; anything far beyond is a hang
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 6000) begin
      n_errors++;
      close_out();
    end
  end

  task automatic close_out();
    $display("errors %0d comparisons %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ****************************************
  // reference model and bus tasks
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // implemented pins per port; the input-only port holds no direction or latch
  function automatic logic [7:0] msk(input int p);
    return p == 2 ? 8'h3F : p == 4 ? 8'h0F : p == 12 ? 8'h1F : p == 3 ? 8'h00 : 8'hFF;
  endfunction

  task automatic reset(input logic [2:0] m);
    @(negedge i_ref_clk);
    i_arst_n = 1'b0;
    i_mode = m;
    foreach (dir[p]) begin
      dir[p] = 0;
      lat[p] = 0;
      odc[p] = 0;
    end
    foreach (pul[k]) pul[k] = 0;
    repeat (2) @(negedge i_ref_clk);
    i_arst_n = 1'b1;
    for (int w = 0; w < 20 && o_ready !== 1'b1; w++) @(negedge i_ref_clk);
  endtask

  // model follows only what the write port accepted at its taking edge
  task automatic wr(input int p, input iops_reg_e r, input logic [7:0] d);
    logic rdy;
    @(negedge i_ref_clk);
    i_wr_en = 1'b1;
    i_wr_port = p[3:0];
    i_wr_reg = r;
    i_wr_data = d;
    rdy = o_ready;
    @(negedge i_ref_clk);
    i_wr_en = 1'b0;
    if (rdy === 1'b1) case (r)
      IOPS_REG_DIR:   dir[p] = d & msk(p);
      IOPS_REG_LATCH: lat[p] = d & msk(p);
      IOPS_REG_PULL:  if (p >= 6 && p <= 10) pul[p-6] = d;
      IOPS_REG_ODC:   if (p == 2 || p == 6) odc[p] = d & msk(p);
      default: ;
    endcase
  endtask

  task automatic rd(input int p, input iops_reg_e r, input logic [7:0] e, input logic [7:0] m);
    @(negedge i_ref_clk);
    i_rd_port = p[3:0];
    i_rd_reg = r;
    @(negedge i_ref_clk);
    `CHK(o_rd_data & m, e & m)
  endtask

  // pin drive and pull-up of every port, valid while no bus function claims pins
  task automatic chk_pins();
    logic [7:0] oe;
    for (int p = 0; p < 13; p++) begin
      oe = 8'(dir[p] & ~(odc[p] & lat[p]));
      `CHK(o_pin_oe[p], oe)
      `CHK(o_pin[p] & oe, 8'(lat[p]) & oe)
      if (p >= 6 && p <= 10) `CHK(o_pullup_en[p-6], 8'(pul[p-6]) & ~oe)
    end
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    static iops_reg_e rs [4] = '{IOPS_REG_DIR, IOPS_REG_LATCH, IOPS_REG_PULL, IOPS_REG_ODC};
    int         p;
    iops_reg_e  r;
    logic [7:0] d;
    {i_arst_n, i_man_rst, i_hw_stby, i_wait_pin_enable, i_clk_phi, i_wr_en} = '0;
    {i_wr_port, i_rd_port, i_wr_data, i_mode} = '0;
    i_wr_reg = IOPS_REG_DIR;
    i_rd_reg = IOPS_REG_PIN;
    i_bus = '0;
    ext_en = '1;
    ext_val = '0;
    reset(3'd7);
    `CHK(o_pin_oe, '0)
    // random writes to every writable register kind, refused targets included
    repeat (60) begin
      seed = lfsr(seed);
      p = int'(seed[3:0]) % 13;
      r = rs[seed[5:4]];
      d = seed[15:8];
      if (p == 11 && r == IOPS_REG_DIR) d[7] = 1'b0;
      ext_val[p] = seed[23:16];
      i_clk_phi = seed[24];
      wr(p, r, d);
      repeat (3) @(negedge i_ref_clk);
      chk_pins();
      rd(p, IOPS_REG_PIN, 8'((dir[p] & lat[p]) | (~dir[p] & ext_val[p])), p == 3 ? 8'hFF : msk(p));
      rd(p, IOPS_REG_DIR, 8'h00, 8'hFF);
    end
    wr(6, IOPS_REG_DIR, 8'h00);
    ext_val[6] = 8'hA5;
    repeat (4) @(negedge i_ref_clk);
    `CHK(o_irq_req, 4'hA)
    // manual reset refuses writes and keeps state; standby clears it
    i_man_rst = 1'b1;
    repeat (3) @(negedge i_ref_clk);
    `CHK(o_ready, 1'b0)
    wr(0, IOPS_REG_DIR, 8'h5A);
    chk_pins();
    i_man_rst = 1'b0;
    i_hw_stby = 1'b1;
    repeat (3) @(negedge i_ref_clk);
    `CHK(o_pin_oe, '0)
    i_hw_stby = 1'b0;
    reset(3'd7);
    // clock output on port F bit 7 follows the system clock level
    wr(11, IOPS_REG_DIR, 8'h80);
    for (int k = 0; k < 2; k++) begin
      @(negedge i_ref_clk);
      i_clk_phi = k[0];
      #1;
      `CHK({o_pin_oe[11][7], o_pin[11][7]}, {1'b1, i_clk_phi})
    end
    // mode 6: address claims follow the direction bits and beat the latch
    reset(3'd6);
    i_bus.addr = 24'h5A_C396;
    wr(7, IOPS_REG_LATCH, 8'h3C);
    wr(7, IOPS_REG_DIR, 8'hFF);
    wr(6, IOPS_REG_DIR, 8'h0F);
    ext_val[6] = 8'h50;
    `CHK({o_pin_oe[7], o_pin[7], o_pin_oe[8]}, {8'hFF, i_bus.addr[15:8], 8'h00})
    `CHK({o_pin_oe[6][3:0], o_pin[6][3:0]}, {4'hF, i_bus.addr[19:16]})
    // port D data pins are claimed but not driven and port E stays an input, so the board levels come back in
    ext_val[9] = 8'h3C;
    ext_val[10] = 8'hC3;
    repeat (4) @(negedge i_ref_clk);
    `CHK(o_irq_req, 4'h5)
    `CHK(o_data_in, 16'h3CC3)
    // mode 4: clock pin starts driving, wait pin swaps between I/O and wait input
    reset(3'd4);
    `CHK(o_pin_oe[11][7], 1'b1)
    wr(11, IOPS_REG_DIR, 8'h84);
    `CHK(o_pin_oe[11][2], 1'b1)
    i_wait_pin_enable = 1'b1;
    ext_val[11] = 8'h04;
    repeat (4) @(negedge i_ref_clk);
    `CHK({o_pin_oe[11][2], o_wait_req}, 2'b01)
    ext_val[11] = 8'h00;
    repeat (4) @(negedge i_ref_clk);
    `CHK(o_wait_req, 1'b0)
    // mode 1: port C address always claimed, clock pin driving from reset
    reset(3'd1);
    `CHK({o_pin_oe[8], o_pin[8], o_pin_oe[11][7]}, {8'hFF, i_bus.addr[7:0], 1'b1})
    // mode 2: port B address only where the direction bit is set
    reset(3'd2);
    wr(7, IOPS_REG_DIR, 8'h01);
    `CHK({o_pin_oe[7], o_pin[7][0], o_pin_oe[11][7]}, {8'h01, i_bus.addr[8], 1'b0})
    close_out();
  end
endmodule // test_io_port_function_select

`default_nettype wire

// ### logic/iops_consts.svh
// constants for the io port function select block: indices, masks, modes, reset values
`ifndef IOPS_CONSTS_SVH
`define IOPS_CONSTS_SVH

// port indices in the packed pin arrays
`define IOPS_P1          4'd0
`define IOPS_P2          4'd1
`define IOPS_P3          4'd2
`define IOPS_P4          4'd3
`define IOPS_P5          4'd4
`define IOPS_P6          4'd5
`define IOPS_PA          4'd6
`define IOPS_PB          4'd7
`define IOPS_PC          4'd8
`define IOPS_PD          4'd9
`define IOPS_PE          4'd10
`define IOPS_PF          4'd11
`define IOPS_PG          4'd12
`define IOPS_NPORTS      13

// implemented pin masks for the narrow ports
`define IOPS_MASK_P3     8'h3F
`define IOPS_MASK_P5     8'h0F
`define IOPS_MASK_PG     8'h1F
`define IOPS_MASK_FULL   8'hFF

// operating modes
`define IOPS_MODE1       3'd1
`define IOPS_MODE2       3'd2
`define IOPS_MODE3       3'd3
`define IOPS_MODE4       3'd4
`define IOPS_MODE5       3'd5
`define IOPS_MODE6       3'd6
`define IOPS_MODE7       3'd7

// reset values
`define IOPS_RST_BYTE    8'h00
`define IOPS_RST_F_CLK   8'h80
`define IOPS_INIT_LOAD   2'd2
`define IOPS_INIT_DONE   2'd3

// port F function pin positions
`define IOPS_F_CLK_BIT   3'd7
`define IOPS_F_WAIT_BIT  3'd2

`endif

// ### logic/iops_pkg.sv
// types shared by the io port function select block
package iops_pkg;

  // register selector on the write and read ports
  typedef enum logic [2:0] {
    IOPS_REG_DIR    = 3'h0,
    IOPS_REG_LATCH  = 3'h1,
    IOPS_REG_PIN    = 3'h2,
    IOPS_REG_PULL   = 3'h3,
    IOPS_REG_ODC    = 3'h4
  } iops_reg_e;

  // external bus controller signals that may claim pins
  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] dout;
    logic        data_oe;
    logic [3:0]  strobe_n;   // as, rd, hwr, lwr (high to low)
    logic        bus16;
  } iops_bus_s;

  typedef logic [12:0][7:0] iops_ports_t;
  typedef logic [4:0][7:0]  iops_pull_t;

endpackage

// ### logic/iops_top.sv
// io port block: direction, output latch, pin-state, pull-up, open-drain and mode pin claims
//
// Overview of operation
// RULE1: each I/O pin direction bit: 1 drives output, 0 input, unless pin claimed.
// RULE2: output latch supplies level on every general-purpose output pin.
// RULE3: read-only pin-state register samples each pin of every port.
// RULE4: twelve I/O ports plus input-only port 4 that never drives.
// RULE5: ports A to E have pull-up control bits per pin.
// RULE6: ports 3 and A have open-drain bits disabling the high-side driver.
// RULE7: direction resets to 0, except clock pin in expanded ROM-less modes resets 1.
// RULE8: ports B, C in expanded ROM modes: direction 0 input, 1 address output.
// RULE9: mode 6 lower port A pins: direction 0 input, 1 address output.
// RULE10: mode 6 upper port A inputs also feed interrupt lines 7 to 4.
// RULE11: single-chip mode upper port A is I/O and feeds interrupt lines 7 to 4.
// RULE12: port F bit 7 input when direction 0, outputs system clock when 1.
// RULE13: expanded modes, port F bit 2 is I/O unless wait enable set, then wait input.
// RULE14: pin-state read returns latch for output bits, pin level for input bits.
// RULE15: direction registers are write-only; a read gives no stored value.
// RULE16: direction and latch clear on power-on and standby, kept over manual reset.
// RULE17: a bus function claiming a pin overrides its direction and latch.
// RULE18: pull-up acts only on input pins, forced off while pin drives.
`timescale 1ns/1ps
`default_nettype none
`include "iops_consts.svh"

module iops_top (
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_arst_n,
  input  wire logic                 i_man_rst,
  input  wire logic                 i_hw_stby,
  input  wire logic [2:0]           i_mode,
  input  wire logic                 i_wait_pin_enable,
  input  wire logic                 i_clk_phi,
  input  wire iops_pkg::iops_bus_s  i_bus,
  input  wire logic                 i_wr_en,
  input  wire logic [3:0]           i_wr_port,
  input  wire iops_pkg::iops_reg_e  i_wr_reg,
  input  wire logic [7:0]           i_wr_data,
  input  wire logic [3:0]           i_rd_port,
  input  wire iops_pkg::iops_reg_e  i_rd_reg,
  input  wire iops_pkg::iops_ports_t i_pin,
  output iops_pkg::iops_ports_t     o_pin,
  output iops_pkg::iops_ports_t     o_pin_oe,
  output iops_pkg::iops_pull_t      o_pullup_en,
  output logic [7:0]                o_rd_data,
  output logic [15:0]               o_data_in,
  output logic [7:4]                o_irq_req,
  output logic                      o_wait_req,
  output logic                      o_ready
);
  import iops_pkg::*;

  // ****************************************
  // mode decoding helpers
  // ****************************************
  function automatic logic is_exp(input logic [2:0] m);
    is_exp = (m != `IOPS_MODE3) && (m != `IOPS_MODE7) && (m != 3'd0);
  endfunction
  function automatic logic is_romless(input logic [2:0] m);
    is_romless = (m == `IOPS_MODE1) || (m == `IOPS_MODE4) || (m == `IOPS_MODE5);
  endfunction
  function automatic logic [7:0] port_mask(input int p);
    port_mask = (p == 2) ? `IOPS_MASK_P3 : (p == 4) ? `IOPS_MASK_P5 :
                (p == 12) ? `IOPS_MASK_PG : `IOPS_MASK_FULL;
  endfunction

  // ****************************************
  // synchronisers for pins, manual reset, standby and mode strap
  // ****************************************
  iops_ports_t pin_s1_q, pin_s2_q;
  logic        mr_s1_q, mr_s2_q, hs_s1_q, hs_s2_q;
  logic [2:0]  mode_s1_q, mode_s2_q, mode_q;
  logic [1:0]  init_cnt_q;

  // first stage feeds only the second stage
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_s1_q  <= '0;
      pin_s2_q  <= '0;
      mr_s1_q   <= 1'b0;
      mr_s2_q   <= 1'b0;
      hs_s1_q   <= 1'b0;
      hs_s2_q   <= 1'b0;
      mode_s1_q <= 3'd0;
      mode_s2_q <= 3'd0;
    end else begin
      pin_s1_q  <= i_pin;
      pin_s2_q  <= pin_s1_q;
      mr_s1_q   <= i_man_rst;
      mr_s2_q   <= mr_s1_q;
      hs_s1_q   <= i_hw_stby;
      hs_s2_q   <= hs_s1_q;
      mode_s1_q <= i_mode;
      mode_s2_q <= mode_s1_q;
    end
  end

  // strap caught after release, once the synchroniser has filled
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      init_cnt_q <= 2'd0;
      mode_q     <= 3'd0;
    end else begin
      if (init_cnt_q != `IOPS_INIT_DONE)
        init_cnt_q <= init_cnt_q + 2'd1;
      if (init_cnt_q == `IOPS_INIT_LOAD)
        mode_q <= mode_s2_q;
    end
  end

  // ****************************************
  // register file
  // ****************************************
  iops_ports_t dir_q, latch_q;
  iops_pull_t  pull_q;
  logic [1:0][7:0] odc_q;       // 0: port 3, 1: port A
  wire  init_load = (init_cnt_q == `IOPS_INIT_LOAD);
  wire  wr_ok     = i_wr_en && !mr_s2_q && !hs_s2_q && (init_cnt_q == `IOPS_INIT_DONE);
  wire  [2:0] rst_mode = init_load ? mode_s2_q : mode_q;
  wire  f_clk_rst = is_romless(rst_mode);

  // clock pin direction starts as output only in expanded ROM-less modes
  wire [7:0] f_dir_rst = f_clk_rst ? `IOPS_RST_F_CLK : `IOPS_RST_BYTE;  // [RULE7]

  genvar p;
  generate
    for (p = 0; p < `IOPS_NPORTS; p++) begin : g_port
      wire sel    = wr_ok && (i_wr_port == 4'(p));
      wire wr_dir = sel && (i_wr_reg == IOPS_REG_DIR) && (p != 3);  // [RULE4]
      wire wr_lat = sel && (i_wr_reg == IOPS_REG_LATCH) && (p != 3);
      // manual reset does not touch these; only power-on and standby clear them
      always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          dir_q[p]   <= `IOPS_RST_BYTE;  // [RULE16]
          latch_q[p] <= `IOPS_RST_BYTE;
        end else if (hs_s2_q || init_load) begin
          dir_q[p]   <= (p == 11) ? f_dir_rst : `IOPS_RST_BYTE;  // [RULE7] [RULE16]
          latch_q[p] <= hs_s2_q ? `IOPS_RST_BYTE : latch_q[p];
        end else begin
          if (wr_dir)
            dir_q[p] <= i_wr_data & port_mask(p);  // [RULE1]
          if (wr_lat)
            latch_q[p] <= i_wr_data & port_mask(p);  // [RULE2]
        end
      end
    end
    for (p = 0; p < 5; p++) begin : g_pull
      wire wr_pull = wr_ok && (i_wr_reg == IOPS_REG_PULL) && (i_wr_port == 4'(p + 6));
      always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n)
          pull_q[p] <= `IOPS_RST_BYTE;
        else if (hs_s2_q)
          pull_q[p] <= `IOPS_RST_BYTE;
        else if (wr_pull)
          pull_q[p] <= i_wr_data;  // [RULE5]
      end
    end
    for (p = 0; p < 2; p++) begin : g_odc
      wire wr_odc = wr_ok && (i_wr_reg == IOPS_REG_ODC) && (i_wr_port == (p == 0 ? `IOPS_P3 : `IOPS_PA));
      always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n)
          odc_q[p] <= `IOPS_RST_BYTE;
        else if (hs_s2_q)
          odc_q[p] <= `IOPS_RST_BYTE;
        else if (wr_odc)
          odc_q[p] <= i_wr_data & port_mask(p == 0 ? 2 : 6);  // [RULE6]
      end
    end
  endgenerate

  // ****************************************
  // pin function claims by mode
  // ****************************************
  wire exp_m  = is_exp(mode_q);
  wire rl_m   = is_romless(mode_q);
  wire rom_m  = (mode_q == `IOPS_MODE2) || (mode_q == `IOPS_MODE6);
  wire m45    = (mode_q == `IOPS_MODE4) || (mode_q == `IOPS_MODE5);
  wire m6     = (mode_q == `IOPS_MODE6);

  // address pins: B, C fixed in ROM-less modes, per direction bit in ROM modes; A per direction bit in modes 4 to 6, lower five fixed in 4, 5
  wire [7:0] b_claim = rl_m ? 8'hFF : rom_m ? dir_q[`IOPS_PB] : 8'h00;  // [RULE8] [RULE17]
  wire [7:0] c_claim = rl_m ? 8'hFF : rom_m ? dir_q[`IOPS_PC] : 8'h00;  // [RULE8] [RULE17]
  wire [7:0] a_claim = m45 ? {dir_q[`IOPS_PA][7:5], 5'h1F} :
                       m6  ? dir_q[`IOPS_PA] : 8'h00;                   // [RULE9] [RULE10]
  wire [7:0] d_claim = exp_m ? 8'hFF : 8'h00;
  wire [7:0] e_claim = (exp_m && i_bus.bus16) ? 8'hFF : 8'h00;
  wire       wait_on = exp_m && i_wait_pin_enable;                      // [RULE13]
  wire [7:0] f_claim = {dir_q[`IOPS_PF][7], {4{exp_m}}, wait_on, 2'b00};  // [RULE12]

  iops_ports_t fclaim, fval, foe;
  assign fclaim = {8'h00, f_claim, e_claim, d_claim, c_claim, b_claim, a_claim, 48'h0000_0000_0000};
  assign fval   = {8'h00, i_clk_phi, i_bus.strobe_n, 3'b000, i_bus.dout[7:0], i_bus.dout[15:8],
                   i_bus.addr[7:0], i_bus.addr[15:8], i_bus.addr[23:16], 48'h0000_0000_0000};
  // wait pin is claimed as an input, so its function enable is low
  assign foe    = {8'h00, 5'h1F, 3'b000, {8{i_bus.data_oe}}, {8{i_bus.data_oe}}, 24'hFF_FFFF,
                   48'h0000_0000_0000};

  // ****************************************
  // pin drivers, open-drain and pull-ups
  // ****************************************
  iops_ports_t gpio_val, gpio_oe, odc_full;
  // each open-drain register sits at its own port index: ports 12..7, A, 5..3, 3rd port, 1..0
  // a misplaced slice here would silently move open-drain onto a neighbouring port
  assign odc_full = {48'h0000_0000_0000, odc_q[1], 24'h00_0000, odc_q[0], 16'h0000};

  generate
    for (p = 0; p < `IOPS_NPORTS; p++) begin : g_drv
      assign gpio_val[p] = latch_q[p];  // [RULE2]
      // open drain: a high level turns the driver off instead of pulling up
      assign gpio_oe[p]  = dir_q[p] & ~(odc_full[p] & latch_q[p]);  // [RULE1] [RULE6]
      assign o_pin[p]    = (fclaim[p] & fval[p]) | (~fclaim[p] & gpio_val[p]);  // [RULE17]
      // input-only port and unimplemented pins never drive
      assign o_pin_oe[p] = (p == 3) ? 8'h00 :
                           (((fclaim[p] & foe[p]) | (~fclaim[p] & gpio_oe[p])) & port_mask(p));  // [RULE4]
    end
    for (p = 0; p < 5; p++) begin : g_pu
      assign o_pullup_en[p] = pull_q[p] & ~o_pin_oe[p + 6];  // [RULE18]
    end
  endgenerate

  // ****************************************
  // pin-state and read port
  // ****************************************
  iops_ports_t pin_state;
  assign pin_state = (dir_q & latch_q) | (~dir_q & pin_s2_q);  // [RULE3] [RULE14]

  wire [7:0] rd_pull = (i_rd_port >= `IOPS_PA && i_rd_port <= `IOPS_PE) ?
                       pull_q[3'(i_rd_port - `IOPS_PA)] : 8'h00;
  wire [7:0] rd_odc  = (i_rd_port == `IOPS_P3) ? odc_q[0] :
                       (i_rd_port == `IOPS_PA) ? odc_q[1] : 8'h00;
  wire       rd_ok   = i_rd_port < 4'(`IOPS_NPORTS);
  // direction is write-only; reads of it return zero, never the stored bits
  wire [7:0] rd_mux  = !rd_ok ? 8'h00 :
                       (i_rd_reg == IOPS_REG_LATCH) ? latch_q[i_rd_port] :
                       (i_rd_reg == IOPS_REG_PIN)   ? pin_state[i_rd_port] :
                       (i_rd_reg == IOPS_REG_PULL)  ? rd_pull :
                       (i_rd_reg == IOPS_REG_ODC)   ? rd_odc : 8'h00;  // [RULE15]

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n)
      o_rd_data <= 8'h00;
    else
      o_rd_data <= rd_mux;
  end

  // ****************************************
  // inputs toward the core
  // ****************************************
  // interrupt lines follow the upper port A pins unless they carry address
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_irq_req  <= 4'h0;
      o_wait_req <= 1'b0;
      o_data_in  <= 16'h0000;
    end else begin
      o_irq_req  <= pin_s2_q[`IOPS_PA][7:4] & ~a_claim[7:4];  // [RULE10] [RULE11]
      o_wait_req <= wait_on & pin_s2_q[`IOPS_PF][`IOPS_F_WAIT_BIT];  // [RULE13]
      o_data_in  <= {pin_s2_q[`IOPS_PD], pin_s2_q[`IOPS_PE]};
    end
  end

  assign o_ready = (init_cnt_q == `IOPS_INIT_DONE) && !mr_s2_q && !hs_s2_q;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);

  dir_out_a: assert property (!fclaim[1][0] |-> (o_pin_oe[1][0] == dir_q[1][0]))  // [RULE1]
    else $error("direction bit does not steer output enable");
  latch_drive_a: assert property ((dir_q[0][3] && !fclaim[0][3]) |-> (o_pin[0][3] == latch_q[0][3]))  // [RULE2]
    else $error("output pin does not follow latch");
  pin_read_a: assert property ((i_rd_reg == IOPS_REG_PIN && i_rd_port == 4'd1)
      |=> o_rd_data == (($past(dir_q[1]) & $past(latch_q[1])) | (~$past(dir_q[1]) & $past(pin_s2_q[1]))))  // [RULE14]
    else $error("pin-state read wrong");
  input_only_a: assert property (o_pin_oe[3] == 8'h00)  // [RULE4]
    else $error("input-only port drives");
  pull_off_a: assert property ((o_pullup_en[3] & o_pin_oe[9]) == 8'h00)  // [RULE18]
    else $error("pull-up on while driving");
  open_drain_a: assert property ((odc_q[0][1] && latch_q[2][1] && dir_q[2][1]) |-> !o_pin_oe[2][1])  // [RULE6]
    else $error("open-drain pin drives high");
  odc_port_a_a: assert property ((odc_q[1][0] && latch_q[6][0] && dir_q[6][0] && !fclaim[6][0])  // [RULE6]
      |-> !o_pin_oe[6][0])
    else $error("port A open-drain pin drives high");
  clk_reset_a: assert property ((init_load && is_romless(mode_s2_q) && !hs_s2_q) |=> dir_q[11][7] ##1 o_pin_oe[11][7])  // [RULE7]
    else $error("clock pin direction not set at reset");
  addr_dir_a: assert property ((mode_q == `IOPS_MODE2 && dir_q[7][0]) |-> (o_pin[7][0] == i_bus.addr[8] && o_pin_oe[7][0]))  // [RULE8]
    else $error("port B address output missing");
  low_a_in_a: assert property ((m6 && !dir_q[6][0]) |-> !o_pin_oe[6][0])  // [RULE9]
    else $error("port A lower pin drives as input");
  irq_feed_a: assert property ((mode_q == `IOPS_MODE7) |=> o_irq_req == $past(pin_s2_q[6][7:4]))  // [RULE11]
    else $error("interrupt lines not fed from port A");
  clk_out_a: assert property (dir_q[11][7] |-> (o_pin[11][7] == i_clk_phi && o_pin_oe[11][7]))  // [RULE12]
    else $error("clock pin not outputting clock");
  wait_in_a: assert property (wait_on |-> !o_pin_oe[11][2])  // [RULE13]
    else $error("wait pin driven while enabled");
  man_keep_a: assert property ((mr_s2_q && !hs_s2_q && !init_load) |=> $stable(dir_q) && $stable(latch_q))  // [RULE16]
    else $error("manual reset altered port registers");
  bus_claim_a: assert property ((mode_q == `IOPS_MODE1) |-> (o_pin[8] == i_bus.addr[7:0] && o_pin_oe[8] == 8'hFF))  // [RULE17]
    else $error("bus function did not take the pin");

endmodule // iops_top

`default_nettype wire
